// ==== test_temperature_measurement_control.sv ====
/*
  Self-checking bench for the measurement control core with short counts.
  Assumes the host model drives all request and sample inputs.
*/
`timescale 1ns/10ps
module test_temperature_measurement_control
  import tmc_pkg::*;
;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam int CL = 20;
  localparam int CM = 30;
  localparam int CH = 50;
  localparam int PB = 200;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  tmc_host_req_t host_req;
  tmc_adc_in_t adc_in;
  logic adc_active, reading_update;
  logic [15:0] temperature_reading;
  logic [7:0] reading_byte, measurement_config, device_status, d;
  logic [15:0] s;
  int w, n, t0, z, cyc, bad_count, comparisons;
  int exp_q[$];
  tmc_host_model u_tmc_host_model (.sys_clk(sys_clk), .host_req(host_req), .adc_in(adc_in));
  tmc_measure_ctrl #(.CONV_LOW_CYCLES(CL), .CONV_MED_CYCLES(CM), .CONV_HIGH_CYCLES(CH),
    .PERIOD_HALF_CYCLES(PB), .PERIOD_ONE_CYCLES(PB + 20), .PERIOD_TWO_CYCLES(PB + 40),
    .PERIOD_FOUR_CYCLES(PB + 60), .PERIOD_TEN_CYCLES(PB + 80)) u_tmc_measure_ctrl (
    .sys_clk(sys_clk), .rst(rst), .host_req(host_req), .adc_in(adc_in),
    .reading_byte_sel(sel), .adc_active(adc_active),
    .temperature_reading(temperature_reading), .reading_byte(reading_byte),
    .measurement_config(measurement_config), .device_status(device_status),
    .reading_update(reading_update));
  // 50 MHz clock and a free cycle count
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset(input int k);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (k) @(posedge sys_clk);
    rst <= 1'b0;
    tick();
    tick();
    check({device_status, measurement_config}, 16'h0800);
    check(16'(adc_active), 16'h0000);
  endtask
  // Start, optionally retry mid-run (must be ignored), time the busy span
  task automatic convert(input logic dup);
    s = 16'($urandom);
    exp_q.push_back((int'(s) - 40 * 256) & 'hFFFF);
    u_tmc_host_model.front(s, 1'b1);
    u_tmc_host_model.send(0, 8'h00);
    #1;
    t0 = cyc;
    if (dup) u_tmc_host_model.send(0, 8'h00);
    while (adc_active === 1'b1 && cyc - t0 < 2000) tick();
    n = cyc - t0;
  endtask
  task automatic byte_chk(input logic b, input logic [7:0] want);
    @(posedge sys_clk);
    sel <= b;
    tick();
    check(reading_byte, want);
  endtask
  task automatic end_sim;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hC3A07597));
    repeat (12) @(posedge sys_clk);
    check({device_status, measurement_config}, 16'h0000);
    rst <= 1'b0;
    tick();
    tick();
    check(device_status, 8'h08);
    u_tmc_host_model.send(5, 8'h00);
    tick();
    check(device_status, 8'h00);
    repeat (6) begin
      d = 8'($urandom);
      u_tmc_host_model.send(1, d);
      tick();
      check(measurement_config, d & 8'h9F);
    end
    // Every repeatability; new setting written before a full conversion
    for (int r = 0; r < 4; r++) begin
      u_tmc_host_model.send(1, 8'(r));
      convert(r[0]);
      check(16'(n), r == 0 ? CL : r == 1 ? CM : CH);
      check(reading_update, 1'b1);
      w = exp_q.pop_front();
      check(temperature_reading, 16'(w));
      byte_chk(1'b1, 8'(w >> 8));
      byte_chk(1'b0, 8'(w));
      repeat (PB - n) tick();
    end
    u_tmc_host_model.send(1, 8'h80);
    convert(1'b0);
    check(device_status[2], 1'b1);
    check(temperature_reading, 16'(exp_q.pop_front()));
    u_tmc_host_model.send(1, 8'h00);
    tick();
    check(device_status[2], 1'b0);
    for (int k = 0; k < 4; k++) begin
      u_tmc_host_model.send(2 + k / 2, 8'(k));
      tick();
      check(device_status[4 + k / 2], k[0]);
    end
    // Periodic rates: one command, then spacing of the next result
    for (int k = 1; k < 6; k++) begin
      u_tmc_host_model.send(1, 8'(k << 2));
      convert(1'b0);
      t0 = cyc;
      z = 0;
      do begin
        tick();
        z += (device_status[0] !== 1'b1);
      end while (reading_update !== 1'b1 && cyc - t0 < 2000);
      check(16'(cyc - t0), 16'(PB + 20 * (k - 1)));
      check(16'(z), 16'h0000);
      check(temperature_reading, 16'(exp_q.pop_front()));
      do_reset(2);
    end
    // Undefined rate converts once; writing single rate ends a periodic run
    u_tmc_host_model.send(1, 8'h18);
    convert(1'b0);
    check(temperature_reading, 16'(exp_q.pop_front()));
    repeat (PB + 100) tick();
    check({7'h00, adc_active, device_status}, 16'h0008);
    u_tmc_host_model.send(1, 8'h14);
    convert(1'b0);
    check(temperature_reading, 16'(exp_q.pop_front()));
    u_tmc_host_model.send(1, 8'h00);
    tick();
    check(device_status, 8'h08);
    repeat (PB + 100) tick();
    check({7'h00, adc_active, device_status}, 16'h0008);
    end_sim();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (10000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
endmodule

// ==== tmc_host_model.sv ====
/*
  Host and front-end model: issues one-cycle command events and holds
  the analog sample. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module tmc_host_model
  import tmc_pkg::*;
(
  input wire logic sys_clk,
  output tmc_host_req_t host_req,
  output tmc_adc_in_t adc_in
);
  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  initial begin
    host_req = '0;
    adc_in = '0;
  end
  // One event per call; kind 0 begin, 1 config, 2 command, 3 write, else clear
  task automatic send(input int kind, input logic [7:0] d);
    tmc_host_req_t r;
    r = '0;
    case (kind)
      0: r.begin_conversion = 1'b1;
      1: begin
        r.config_write = 1'b1;
        r.config_data = d;
      end
      2: begin
        r.command_done = 1'b1;
        r.command_ok = d[0];
      end
      3: begin
        r.write_seq_done = 1'b1;
        r.write_crc_bad = d[0];
      end
      default: r.reset_flag_clear = 1'b1;
    endcase
    @(posedge sys_clk);
    host_req <= r;
    @(posedge sys_clk);
    host_req <= '0;
  endtask
  // Sample held steady across the whole conversion
  task automatic front(input logic [15:0] s, input logic a);
    @(posedge sys_clk);
    adc_in <= {s, a};
  endtask
endmodule

// ==== tmc_measure_ctrl.sv ====
/*
  Measurement control core of the digital thermometer: conversion
  sequencing in single and periodic modes, the reading, the configuration
  byte and the status byte.
  A start request during a conversion or a periodic run is dropped
  without any sign; the host sees the activity only in status bit 0.
  The cycle counter is 32 bits wide, enough for the slowest period at
  the default clock; a much faster clock would need a wider counter.
  Assumes the serial engines deliver decoded one-cycle event pulses, and
  that the analog front end holds a valid sample while conversion runs.
  The threshold comparison itself lives outside; only its verdict is
  sampled here, at the end of each conversion.
*/
// Summary of operation
// (R1) After reset the block idles and converts nothing until commanded.
// (R2) Begin-conversion starts a measurement; the result lands in the reading.
// (R3) Repeatability resets to low, the shortest conversion.
// (R4) Reading is 16-bit two's complement, one LSB is 1/256 degree.
// (R5) Bit 15 is sign, bits 14:8 integer, bits 7:0 fraction.
// (R6) Reading is offset coded: Celsius equals 40 plus reading/256.
// (R7) Non-single rate makes one command repeat conversions at that interval.
// (R8) Configuration bit 7 enables the alarm; resets to zero.
// (R9) Configuration bits 4:2 select the periodic rate, default single.
// (R10) Bits 1:0 choose conversion time: 4, 5.5 or 10.5 ms.
// (R11) Host waits a full new conversion after changing repeatability.
// (R12) Status bit 0 shows a measurement is running; resets to zero.
// (R13) Status bit 2 shows the alarm has triggered; resets to zero.
// (R14) Status bit 4 shows last command accepted; resets to zero.
// (R15) Status bit 5 flags bad write checksum; resets to zero.
// (R16) Host may instead loop single measurements with its own padding delay.
// (R17) Status bit 3 reports a detected system reset.
// (R18) Reserved configuration and status bits read zero, ignore writes.
`timescale 1ns/10ps
module tmc_measure_ctrl
  import tmc_pkg::*;
#(
  parameter int CONV_LOW_CYCLES = CONV_DUR_LOW_CYC,
  parameter int CONV_MED_CYCLES = CONV_DUR_MED_CYC,
  parameter int CONV_HIGH_CYCLES = CONV_DUR_HIGH_CYC,
  parameter int PERIOD_HALF_CYCLES = TPER_HALF_CYC,
  parameter int PERIOD_ONE_CYCLES = TPER_ONE_CYC,
  parameter int PERIOD_TWO_CYCLES = TPER_TWO_CYC,
  parameter int PERIOD_FOUR_CYCLES = TPER_FOUR_CYC,
  parameter int PERIOD_TEN_CYCLES = TPER_TEN_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire tmc_host_req_t host_req,
  input wire tmc_adc_in_t adc_in,
  input wire logic reading_byte_sel,
  output logic adc_active,
  output logic [15:0] temperature_reading,
  output logic [7:0] reading_byte,
  output logic [7:0] measurement_config,
  output logic [7:0] device_status,
  output logic reading_update
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    // Sequencer
    tmc_state_t fsm;
    logic [31:0] count;
    logic periodic_run;
    logic [2:0] run_rate;
    logic [1:0] run_rep;
    // Configuration and result
    tmc_config_t cfg;
    logic [15:0] reading;
    logic reading_update;
    // Status flags
    logic alarm_seen;
    logic reset_seen;
    logic reset_pending;
    logic cmd_ok;
    logic crc_bad;
    // Registered pin copies
    logic measuring;
    logic converting;
  } tmc_ctrl_state_t;

  tmc_ctrl_state_t state;
  tmc_ctrl_state_t next_state;

  // ----------------------------------------------------------------------
  // Timing lookups
  // ----------------------------------------------------------------------
  // Code 11 is undefined; treated as high so the wait is never too short
  function automatic logic [31:0] conv_cycles(input logic [1:0] rep);
    logic [31:0] cyc;
    cyc = 32'(CONV_HIGH_CYCLES);
    case (rep)
      REP_LOW: cyc = 32'(CONV_LOW_CYCLES);
      REP_MED: cyc = 32'(CONV_MED_CYCLES);
      REP_HIGH: cyc = 32'(CONV_HIGH_CYCLES);
      default: cyc = 32'(CONV_HIGH_CYCLES);
    endcase
    return cyc;
  endfunction

  // Interval from one conversion start to the next
  // Undefined rate codes never reach here while a run is going
  function automatic logic [31:0] period_cycles(input logic [2:0] rate);
    logic [31:0] cyc;
    cyc = 32'(PERIOD_ONE_CYCLES);
    case (rate)
      RATE_HALF: cyc = 32'(PERIOD_HALF_CYCLES);
      RATE_ONE: cyc = 32'(PERIOD_ONE_CYCLES);
      RATE_TWO: cyc = 32'(PERIOD_TWO_CYCLES);
      RATE_FOUR: cyc = 32'(PERIOD_FOUR_CYCLES);
      RATE_TEN: cyc = 32'(PERIOD_TEN_CYCLES);
      default: cyc = 32'(PERIOD_ONE_CYCLES);
    endcase
    return cyc;
  endfunction

  // Rates 110 and 111 are undefined and behave as single shots
  function automatic logic is_periodic(input logic [2:0] rate);
    return (rate >= RATE_HALF) && (rate <= RATE_TEN);
  endfunction

  // Offset coding: absolute Celsius*256 minus 40 degrees
  // Wraps modulo 2^16, the same as the reading on the pins
  function automatic logic [15:0] offset_code(input logic [15:0] abs_q8);
    return abs_q8 - TEMP_OFFSET_Q8;
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer decisions
  // ----------------------------------------------------------------------
  // A start is taken only from rest; a repeat request mid-run has no effect
  logic start_taken;
  logic conv_done;
  logic period_done;

  assign start_taken = host_req.begin_conversion && !state.measuring &&
    (state.fsm == TMC_IDLE); // R1
  // Counts include the start edge, so each compare lands on the exact cycle
  assign conv_done = state.count >= conv_cycles(state.run_rep); // R10
  assign period_done = state.count >= period_cycles(state.run_rate); // R7

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    // Hold by default; the two pulse fields fall back to zero
    next_state = state;
    next_state.reading_update = 1'b0;
    next_state.reset_pending = 1'b0;

    // Configuration write; reserved bits dropped on the way in
    // A new rate or repeatability takes effect at the next start
    if (host_req.config_write) begin
      next_state.cfg = tmc_config_t'(host_req.config_data & CFG_WRITE_MASK); // R18 R8 R9 R10
      // Selecting single rate ends a running periodic sequence
      if (!is_periodic(host_req.config_data[4:2])) begin
        next_state.periodic_run = 1'b0; // R7
      end
    end

    // Conversion sequencer
    case (state.fsm)
      TMC_IDLE: begin
        // Nothing happens here until the host asks
        if (start_taken) begin // R1
          next_state.fsm = TMC_CONVERT; // R2
          next_state.count = 32'h0000_0001;
          next_state.run_rep = state.cfg.repeatability; // R10
          next_state.run_rate = state.cfg.sample_rate_select;
          next_state.periodic_run = is_periodic(state.cfg.sample_rate_select); // R7
        end
      end
      // Count up to the conversion length latched at the start
      TMC_CONVERT: begin
        next_state.count = state.count + 32'h0000_0001;
        if (conv_done) begin // R10
          next_state.reading = offset_code(adc_in.sample_q8); // R2 R4 R5 R6
          next_state.reading_update = 1'b1;
          // Alarm tracking only while enabled; latched until disabled
          if (state.cfg.alarm_enable && adc_in.alarm_condition) begin
            next_state.alarm_seen = 1'b1; // R13
          end
          if (next_state.periodic_run) begin
            next_state.fsm = TMC_WAIT; // R7
          end else begin
            next_state.fsm = TMC_IDLE;
          end
        end
      end
      // Period runs from one start to the next, conversion included
      TMC_WAIT: begin
        next_state.count = state.count + 32'h0000_0001;
        if (!state.periodic_run) begin
          next_state.fsm = TMC_IDLE;
        end else if (period_done) begin
          // Restart with the current repeatability, no command needed
          next_state.fsm = TMC_CONVERT; // R7
          next_state.count = 32'h0000_0001;
          next_state.run_rep = state.cfg.repeatability;
          next_state.run_rate = state.cfg.sample_rate_select;
        end
      end
      // Illegal encoding recovers to rest
      default: begin
        next_state.fsm = TMC_IDLE;
      end
    endcase

    // Alarm flag drops when the function is switched off
    if (!next_state.cfg.alarm_enable) begin
      next_state.alarm_seen = 1'b0; // R8 R13
    end

    // Last command outcome
    if (host_req.command_done) begin
      next_state.cmd_ok = host_req.command_ok; // R14
    end

    // Last write sequence checksum outcome
    if (host_req.write_seq_done) begin
      next_state.crc_bad = host_req.write_crc_bad; // R15
    end

    // Reset flag: the set after reset wins over a clear in the same cycle
    if (host_req.reset_flag_clear) begin
      next_state.reset_seen = 1'b0;
    end
    if (state.reset_pending) begin
      next_state.reset_seen = 1'b1; // R17
    end

    // Pin copies from the settled next state, so outputs leave flip-flops
    next_state.converting = (next_state.fsm == TMC_CONVERT);
    next_state.measuring = next_state.periodic_run | next_state.converting; // R12
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset takes constants only; the reset flag is raised one edge later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state.fsm <= TMC_IDLE; // R1
      state.count <= 32'h0000_0000;
      state.periodic_run <= 1'b0;
      state.run_rate <= RATE_SINGLE;
      state.run_rep <= REP_LOW;
      state.cfg <= tmc_config_t'(CFG_RESET); // R3 R8 R9
      state.reading <= READING_RESET;
      state.reading_update <= 1'b0;
      state.alarm_seen <= 1'b0;
      state.reset_seen <= 1'b0;
      state.reset_pending <= 1'b1; // R17
      state.cmd_ok <= 1'b0;
      state.crc_bad <= 1'b0;
      // Pin copies follow the idle sequencer
      state.measuring <= 1'b0; // R12
      state.converting <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Result store for byte-wise reads
  // ----------------------------------------------------------------------
  // Fed from the next state so both bytes land on the update edge;
  // a byte read therefore never mixes an old and a new half
  tmc_result_store u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(next_state.reading_update),
    .wr_word(next_state.reading),
    .rd_addr(reading_byte_sel),
    .rd_byte(reading_byte)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Status byte; reserved bits tied low
  always_comb begin
    device_status = 8'h00; // R18
    device_status[ST_MEASURING_BIT] = state.measuring; // R12
    device_status[ST_ALARM_BIT] = state.alarm_seen; // R13
    device_status[ST_RESET_SEEN_BIT] = state.reset_seen; // R17
    device_status[ST_CMD_OK_BIT] = state.cmd_ok; // R14
    device_status[ST_CRC_BAD_BIT] = state.crc_bad; // R15
  end

  // Registered values straight to the pins
  assign measurement_config = state.cfg;
  assign temperature_reading = state.reading;
  assign reading_update = state.reading_update;
  assign adc_active = state.converting;

endmodule

// ==== tmc_measure_ctrl_props.sv ====
/*
  Checker for the measurement control core, bound to its ports.
  Assumes one clock and resets of at least two cycles.
*/
`timescale 1ns/10ps
module tmc_measure_ctrl_props
  import tmc_pkg::*;
#(
  parameter int CONV_LOW_CYCLES = CONV_DUR_LOW_CYC,
  parameter int CONV_MED_CYCLES = CONV_DUR_MED_CYC,
  parameter int CONV_HIGH_CYCLES = CONV_DUR_HIGH_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire tmc_host_req_t host_req,
  input wire tmc_adc_in_t adc_in,
  input wire logic reading_byte_sel,
  input wire logic adc_active,
  input wire logic [15:0] temperature_reading,
  input wire logic [7:0] reading_byte,
  input wire logic [7:0] measurement_config,
  input wire logic [7:0] device_status,
  input wire logic reading_update
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Run length of the converter
  // ----------------------------------------------------------------
  int run_len;
  int exp_len;
  logic [1:0] rep_l;
  // Repeatability frozen while converting, as the core latches it at start
  always_ff @(posedge sys_clk) begin
    run_len <= (rst || !adc_active) ? 0 : run_len + 1;
    rep_l <= adc_active ? rep_l : measurement_config[1:0];
  end
  assign exp_len = (rep_l == 2'h0) ? CONV_LOW_CYCLES :
    (rep_l == 2'h1) ? CONV_MED_CYCLES : CONV_HIGH_CYCLES;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence conv_start;
    host_req.begin_conversion && !adc_active && !device_status[0];
  endsequence
  sequence conv_end;
    $fell(adc_active);
  endsequence
  cfg_write_a: assert property (host_req.config_write |=>
    measurement_config == ($past(host_req.config_data) & 8'h9F)) else $error("config write");
  reserved_zero_a: assert property (measurement_config[6:5] == 2'h0 &&
    device_status[7:6] == 2'h0 && !device_status[1]) else $error("reserved bit set");
  start_conv_a: assert property (conv_start |=> adc_active && device_status[0])
    else $error("no start");
  idle_hold_a: assert property (!adc_active && !device_status[0] &&
    !host_req.begin_conversion |=> !adc_active) else $error("self start");
  conv_len_a: assert property (conv_end |-> run_len == exp_len)
    else $error("conversion length");
  conv_done_a: assert property (conv_end |-> reading_update) else $error("no update");
  alarm_set_a: assert property ($rose(device_status[2]) |-> measurement_config[7])
    else $error("alarm while disabled");
  alarm_off_a: assert property (!measurement_config[7] ##1 !measurement_config[7]
    |-> !device_status[2]) else $error("alarm not cleared");
  cmd_status_a: assert property (host_req.command_done |=>
    device_status[4] == $past(host_req.command_ok)) else $error("command status");
  crc_status_a: assert property (host_req.write_seq_done |=>
    device_status[5] == $past(host_req.write_crc_bad)) else $error("crc status");
  reset_seen_a: assert property ($fell(rst) |=> device_status[3])
    else $error("reset not flagged");
  periodic_a: assert property (conv_end ##0 measurement_config[4:2] inside {[3'h1:3'h5]}
    |-> ##[1:1000] ($rose(adc_active) || !device_status[0]))
    else $error("no periodic restart");
endmodule
bind tmc_measure_ctrl tmc_measure_ctrl_props #(.CONV_LOW_CYCLES(CONV_LOW_CYCLES),
  .CONV_MED_CYCLES(CONV_MED_CYCLES), .CONV_HIGH_CYCLES(CONV_HIGH_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst(rst), .host_req(host_req), .adc_in(adc_in),
  .reading_byte_sel(reading_byte_sel), .adc_active(adc_active),
  .temperature_reading(temperature_reading), .reading_byte(reading_byte),
  .measurement_config(measurement_config), .device_status(device_status),
  .reading_update(reading_update));

// ==== tmc_pkg.sv ====
/*
  Package for the temperature measurement control block: field layouts,
  reset values, timing figures and the state and carrier types.
  Assumes a single 50 MHz system clock and a synchronous active-high reset.
*/
package tmc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int CLK_PER_US = CLK_FREQ_HZ / 1_000_000;
  localparam int CLK_PER_MS = CLK_FREQ_HZ / 1_000;
  // Conversion durations in microseconds
  localparam int CONV_DUR_LOW_US = 4000;
  localparam int CONV_DUR_MED_US = 5500;
  localparam int CONV_DUR_HIGH_US = 10500;
  localparam int CONV_DUR_LOW_CYC = CONV_DUR_LOW_US * CLK_PER_US;
  localparam int CONV_DUR_MED_CYC = CONV_DUR_MED_US * CLK_PER_US;
  localparam int CONV_DUR_HIGH_CYC = CONV_DUR_HIGH_US * CLK_PER_US;
  // Periodic intervals in milliseconds (0.5, 1, 2, 4, 10 per second)
  localparam int TPER_HALF_MS = 2000;
  localparam int TPER_ONE_MS = 1000;
  localparam int TPER_TWO_MS = 500;
  localparam int TPER_FOUR_MS = 250;
  localparam int TPER_TEN_MS = 100;
  localparam int TPER_HALF_CYC = TPER_HALF_MS * CLK_PER_MS;
  localparam int TPER_ONE_CYC = TPER_ONE_MS * CLK_PER_MS;
  localparam int TPER_TWO_CYC = TPER_TWO_MS * CLK_PER_MS;
  localparam int TPER_FOUR_CYC = TPER_FOUR_MS * CLK_PER_MS;
  localparam int TPER_TEN_CYC = TPER_TEN_MS * CLK_PER_MS;

  // ----------------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] RATE_SINGLE = 3'h0;
  localparam logic [2:0] RATE_HALF = 3'h1;
  localparam logic [2:0] RATE_ONE = 3'h2;
  localparam logic [2:0] RATE_TWO = 3'h3;
  localparam logic [2:0] RATE_FOUR = 3'h4;
  localparam logic [2:0] RATE_TEN = 3'h5;
  localparam logic [1:0] REP_LOW = 2'h0;
  localparam logic [1:0] REP_MED = 2'h1;
  localparam logic [1:0] REP_HIGH = 2'h2;
  // Celsius offset of the reading, 40 degrees in 1/256 units
  localparam logic [15:0] TEMP_OFFSET_Q8 = 16'h2800;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h9F;
  localparam logic [15:0] READING_RESET = 16'h0000;
  // Status byte bit positions
  localparam int ST_MEASURING_BIT = 0;
  localparam int ST_ALARM_BIT = 2;
  localparam int ST_RESET_SEEN_BIT = 3;
  localparam int ST_CMD_OK_BIT = 4;
  localparam int ST_CRC_BAD_BIT = 5;
  // Result store layout
  localparam int STORE_DEPTH = 2;
  localparam logic STORE_LOW_BYTE = 1'b0;
  localparam logic STORE_HIGH_BYTE = 1'b1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic alarm_enable;
    logic [1:0] reserved;
    logic [2:0] sample_rate_select;
    logic [1:0] repeatability;
  } tmc_config_t;

  typedef enum logic [1:0] {TMC_IDLE, TMC_CONVERT, TMC_WAIT} tmc_state_t;

  // Events arriving from the serial protocol engines
  typedef struct packed {
    logic begin_conversion;
    logic config_write;
    logic [7:0] config_data;
    logic command_done;
    logic command_ok;
    logic write_seq_done;
    logic write_crc_bad;
    logic reset_flag_clear;
  } tmc_host_req_t;

  // Analog front end handshake
  typedef struct packed {
    logic [15:0] sample_q8;
    logic alarm_condition;
  } tmc_adc_in_t;

endpackage

// ==== tmc_result_store.sv ====
/*
  Two-byte store for the temperature reading, byte addressed for the
  serial engines. Read data come out of a register one cycle after the
  address. Assumes writes and reads are on the same clock.
*/
`timescale 1ns/10ps
module tmc_result_store
  import tmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_word,
  input wire logic rd_addr,
  output logic [7:0] rd_byte
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [STORE_DEPTH-1:0][7:0] mem;
    logic [7:0] rd_byte;
  } tmc_store_state_t;

  tmc_store_state_t state;
  tmc_store_state_t next_state;

  // Whole word written at once so the two bytes never tear
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.mem[STORE_LOW_BYTE] = wr_word[7:0];
      next_state.mem[STORE_HIGH_BYTE] = wr_word[15:8];
    end
    next_state.rd_byte = state.mem[rd_addr];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_byte = state.rd_byte;

endmodule
